// file: verilog/sdcp_pkg.sv
// shared constants and types of the synthesizer divider configuration port
package sdcp_pkg;
	// register addresses carried in the register address byte
	localparam logic [7:0] REG_CFG_LOW = 8'h00; // divider_config_low
	localparam logic [7:0] REG_CFG_HIGH = 8'h01; // divider_config_high
	localparam logic [7:0] REG_COMMAND = 8'hF0; // command_port, write only
	// command_port byte codes
	localparam logic [7:0] CMD_APPLY = 8'h01; // config registers to latches
	localparam logic [7:0] CMD_CAPTURE = 8'h02; // latches to config registers
	localparam logic [7:0] CMD_STEP_UP = 8'h03; // feedback divider plus one
	localparam logic [7:0] CMD_STEP_DOWN = 8'h04; // feedback divider minus one
	// field widths
	localparam int M_W = 10; // feedback divider width
	localparam int NA_W = 3; // output A divider code width
	localparam int LOW_W = 8; // feedback bits held in divider_config_low
	// field positions inside divider_config_high
	localparam int HI_M_LSB = 0; // feedback divider bits 9:8
	localparam int HI_NB_BIT = 2; // output B halver
	localparam int HI_P_BIT = 3; // prescale select
	localparam int HI_NA_LSB = 4; // output A divider code
	localparam logic [7:0] HIGH_MASK = 8'h7F; // top bit reads as zero
	// startup divider values
	localparam logic [M_W-1:0] DEF_M = 10'h1F4; // feedback 500
	localparam logic [NA_W-1:0] DEF_NA = 3'h2; // output A code 010
	localparam logic DEF_NB = 1'b0; // output B undivided
	localparam logic DEF_P = 1'b1; // prescale by four
	// target address upper five bits, lower two come from pins
	localparam logic [4:0] TARGET_ADDR_HI = 5'h16;
	// bits per byte on the serial link
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// fast-mode rate; at 25 MHz one bit spans at least 62 clocks
	localparam int FAST_MODE_KBPS = 400;
	// startup capture waits for the pin synchronisers to fill
	localparam logic [1:0] STARTUP_WAIT = 2'h3;
	localparam logic [1:0] STARTUP_LOAD = 2'h1;
	localparam logic [1:0] STARTUP_DONE = 2'h0;
	// serial engine states
	typedef enum logic [2:0] {
		ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_HACK, ST_WAIT
	} sdcp_state_t;
	// purpose of the byte being received
	typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} sdcp_kind_t;

	// pack divider fields into the layout of divider_config_high
	function automatic logic [7:0] sdcp_pack_high(input logic [M_W-1:0] m,
		input logic [NA_W-1:0] na, input logic nb, input logic p);
		logic [7:0] h;
		h = 8'h00;
		h[HI_M_LSB +: (M_W - LOW_W)] = m[M_W-1:LOW_W];
		h[HI_NB_BIT] = nb;
		h[HI_P_BIT] = p;
		h[HI_NA_LSB +: NA_W] = na;
		return h;
	endfunction
endpackage

// file: verilog/sdcp_sync.sv
// two flip-flop synchroniser for pins entering the clock domain
module sdcp_sync #(
	parameter int WIDTH = 1, // number of bits
	parameter logic [WIDTH-1:0] RST_VAL = '0 // value held during reset
) (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // synchronised reset, active low
	input wire logic [WIDTH-1:0] d_i, // asynchronous input
	output logic [WIDTH-1:0] q_o // synchronised output
);
	logic [WIDTH-1:0] meta; // first stage, read only by the second

	// both stages reset to a constant
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // sdcp_sync

// file: verilog/sdcp_rst_sync.sv
// reset synchroniser: asynchronous assertion, release on the clock
module sdcp_rst_sync (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // raw master reset, active low
	output logic rst_n_o // released copy, active low
);
	logic stage; // first stage of the release chain

	// release passes two flops so no flop sees a partial release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage <= 1'b0;
			rst_n_o <= 1'b0;
		end else begin
			stage <= 1'b1;
			rst_n_o <= stage;
		end
	end
endmodule // sdcp_rst_sync

// file: verilog/sdcp_config_port.sv
// serial configuration port and divider latches of the clock synthesizer
module sdcp_config_port #(
	parameter logic [7:0] PART_SIGNATURE = 8'hA5 // arbitrary value
) (
	input wire logic clk_i, // 25 MHz system clock
	input wire logic rst_n_i, // master_reset_n, active low
	input wire logic scl_i, // serial clock pin
	input wire logic sda_i, // serial data pin level
	output logic sda_o, // serial data drive value
	output logic sda_oe_o, // serial data drive enable, high drives
	input wire logic [1:0] addr_sel_i, // target address low bits
	input wire logic parallel_mode_n_i, // low selects parallel mode
	input wire logic [sdcp_pkg::M_W-1:0] m_pin_i, // feedback divider pins
	input wire logic [sdcp_pkg::NA_W-1:0] na_pin_i, // output A code pins
	input wire logic nb_pin_i, // output B halver pin
	input wire logic p_pin_i, // prescale pin
	output logic [sdcp_pkg::M_W-1:0] feedback_divider_o, // feedback latch
	output logic [sdcp_pkg::NA_W-1:0] output_a_divider_o, // output A latch
	output logic output_b_halver_o, // output B latch
	output logic prescale_o // prescale latch
);
	////////////////////////////////////////////////////////////////
	// reset and pin synchronisation
	logic rst_n; // released reset copy
	logic scl_s; // synchronised serial clock
	logic sda_s; // synchronised serial data
	logic par_n_s; // synchronised mode select
	logic [1:0] addr_sel_s; // synchronised address select
	logic [sdcp_pkg::M_W-1:0] m_s; // synchronised feedback pins
	logic [sdcp_pkg::NA_W-1:0] na_s; // synchronised output A pins
	logic nb_s; // synchronised output B pin
	logic p_s; // synchronised prescale pin
	sdcp_rst_sync u_rst (.clk_i(clk_i), .rst_n_i(rst_n_i), .rst_n_o(rst_n));
	// bus lines idle high, so they reset high to avoid false edges
	sdcp_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_bus (.clk_i(clk_i), .rst_n_i(rst_n),
		.d_i({scl_i, sda_i, parallel_mode_n_i}), .q_o({scl_s, sda_s, par_n_s}));
	sdcp_sync #(.WIDTH(sdcp_pkg::M_W + sdcp_pkg::NA_W + 4)) u_sync_pins (.clk_i(clk_i),
		.rst_n_i(rst_n), .d_i({m_pin_i, na_pin_i, nb_pin_i, p_pin_i, addr_sel_i}),
		.q_o({m_s, na_s, nb_s, p_s, addr_sel_s}));

	////////////////////////////////////////////////////////////////
	// line event detection
	logic scl_q; // previous serial clock
	logic sda_q; // previous serial data
	logic scl_rise; // serial clock rising
	logic scl_fall; // serial clock falling
	logic start_det; // data falls while clock high
	logic stop_det; // data rises while clock high

	// previous levels for edge detection
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det = scl_s && scl_q && !sda_q && sda_s;

	////////////////////////////////////////////////////////////////
	// serial target engine
	sdcp_pkg::sdcp_state_t state; // engine state
	sdcp_pkg::sdcp_kind_t kind; // purpose of byte in reception
	logic [3:0] bit_cnt; // bits shifted in the current byte
	logic [7:0] rx_shift; // received bits
	logic [7:0] tx_shift; // bits being returned
	logic [7:0] reg_ptr; // register address byte of the pair
	logic is_read; // transfer direction from address byte
	logic [1:0] rd_idx; // next byte of the read sequence
	logic wr_stb; // one-cycle pulse: data byte received
	logic [7:0] wr_addr; // register address of that byte
	logic [7:0] wr_data; // data of that byte
	logic [7:0] cfg_low; // divider_config_low
	logic [7:0] cfg_high; // divider_config_high
	logic [7:0] rd_byte; // byte selected for return

	// read order low, high, signature; command has no read path
	always_comb begin
		case (rd_idx)
			2'h0: rd_byte = cfg_low;
			2'h1: rd_byte = cfg_high;
			default: rd_byte = PART_SIGNATURE;
		endcase
	end

	// byte engine; start and stop win over any state
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= sdcp_pkg::ST_IDLE;
			kind <= sdcp_pkg::K_ADDR;
			bit_cnt <= 4'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			reg_ptr <= 8'h00;
			is_read <= 1'b0;
			rd_idx <= 2'h0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (start_det) begin
				// repeated start restarts address reception
				state <= sdcp_pkg::ST_RX;
				kind <= sdcp_pkg::K_ADDR;
				bit_cnt <= 4'h0;
			end else if (stop_det) begin
				state <= sdcp_pkg::ST_IDLE;
			end else begin
				case (state)
					sdcp_pkg::ST_RX: begin
						if (scl_rise) begin
							rx_shift <= {rx_shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == sdcp_pkg::BYTE_BITS) begin
							bit_cnt <= 4'h0;
							case (kind)
								sdcp_pkg::K_ADDR: begin
									// only our address is acknowledged
									if (rx_shift[7:1] == {sdcp_pkg::TARGET_ADDR_HI, addr_sel_s}) begin
										state <= sdcp_pkg::ST_ACK;
										is_read <= rx_shift[0];
									end else begin
										state <= sdcp_pkg::ST_WAIT;
									end
								end
								sdcp_pkg::K_REG: begin
									reg_ptr <= rx_shift;
									state <= sdcp_pkg::ST_ACK;
								end
								default: begin
									// every data byte is acknowledged, even ignored ones
									wr_stb <= 1'b1;
									wr_addr <= reg_ptr;
									wr_data <= rx_shift;
									state <= sdcp_pkg::ST_ACK;
								end
							endcase
						end
					end
					sdcp_pkg::ST_ACK: begin
						if (scl_fall) begin
							if (is_read) begin
								// data follows the address with no register byte, starting at divider_config_low
								state <= sdcp_pkg::ST_TX;
								tx_shift <= cfg_low;
								rd_idx <= 2'h1;
							end else begin
								state <= sdcp_pkg::ST_RX;
								kind <= (kind == sdcp_pkg::K_REG) ? sdcp_pkg::K_DATA
									: sdcp_pkg::K_REG;
							end
						end
					end
					sdcp_pkg::ST_TX: begin
						if (scl_fall) begin
							if (bit_cnt == sdcp_pkg::BYTE_BITS - 4'h1) begin
								bit_cnt <= 4'h0;
								state <= sdcp_pkg::ST_HACK;
							end else begin
								bit_cnt <= bit_cnt + 4'h1;
								tx_shift <= {tx_shift[6:0], 1'b0};
							end
						end
					end
					sdcp_pkg::ST_HACK: begin
						// host not-acknowledge ends the read
						if (scl_rise && sda_s) begin
							state <= sdcp_pkg::ST_WAIT;
						end else if (scl_fall) begin
							state <= sdcp_pkg::ST_TX;
							tx_shift <= rd_byte;
							rd_idx <= (rd_idx == 2'h2) ? 2'h0 : rd_idx + 2'h1;
						end
					end
					sdcp_pkg::ST_WAIT: state <= sdcp_pkg::ST_WAIT; // idle until start/stop
					default: state <= sdcp_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// open-drain data: only ever pulled low, registered to stay glitch free
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_o <= 1'b0;
		end else begin
			sda_oe_o <= (state == sdcp_pkg::ST_ACK)
				|| (state == sdcp_pkg::ST_TX && !tx_shift[7]);
		end
	end

	assign sda_o = 1'b0;

	////////////////////////////////////////////////////////////////
	// startup capture and command decode
	logic [1:0] startup_cnt; // countdown from reset release
	logic wr_ok; // accepted write: serial mode, startup over
	logic cmd_stb; // command byte accepted
	logic [7:0] pins_high; // pin setting in high register layout

	// waits until the pin synchronisers hold real pin levels
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			startup_cnt <= sdcp_pkg::STARTUP_WAIT;
		end else if (startup_cnt != sdcp_pkg::STARTUP_DONE) begin
			startup_cnt <= startup_cnt - 2'h1;
		end
	end

	assign wr_ok = wr_stb && par_n_s && (startup_cnt == sdcp_pkg::STARTUP_DONE);
	assign cmd_stb = wr_ok && (wr_addr == sdcp_pkg::REG_COMMAND);
	assign pins_high = sdcp_pkg::sdcp_pack_high(m_s, na_s, nb_s, p_s);

	////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_low <= sdcp_pkg::DEF_M[sdcp_pkg::LOW_W-1:0];
			cfg_high <= sdcp_pkg::sdcp_pack_high(sdcp_pkg::DEF_M, sdcp_pkg::DEF_NA,
				sdcp_pkg::DEF_NB, sdcp_pkg::DEF_P);
		end else if (!par_n_s) begin
			cfg_low <= m_s[sdcp_pkg::LOW_W-1:0];
			cfg_high <= pins_high;
		end else if (wr_ok && wr_addr == sdcp_pkg::REG_CFG_LOW) begin
			cfg_low <= wr_data;
		end else if (wr_ok && wr_addr == sdcp_pkg::REG_CFG_HIGH) begin
			cfg_high <= wr_data & sdcp_pkg::HIGH_MASK;
		end else if (cmd_stb && wr_data == sdcp_pkg::CMD_CAPTURE) begin
			cfg_low <= feedback_divider_o[sdcp_pkg::LOW_W-1:0];
			cfg_high <= sdcp_pkg::sdcp_pack_high(feedback_divider_o, output_a_divider_o,
				output_b_halver_o, prescale_o);
		end
	end

	////////////////////////////////////////////////////////////////
	// divider latches; unknown codes and plain register writes leave them
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			feedback_divider_o <= sdcp_pkg::DEF_M;
			output_a_divider_o <= sdcp_pkg::DEF_NA;
			output_b_halver_o <= sdcp_pkg::DEF_NB;
			prescale_o <= sdcp_pkg::DEF_P;
		end else if (!par_n_s || startup_cnt == sdcp_pkg::STARTUP_LOAD) begin
			feedback_divider_o <= m_s;
			output_a_divider_o <= na_s;
			output_b_halver_o <= nb_s;
			prescale_o <= p_s;
		end else if (cmd_stb) begin
			case (wr_data)
				sdcp_pkg::CMD_APPLY: begin
					feedback_divider_o <= {cfg_high[sdcp_pkg::HI_M_LSB +: 2], cfg_low};
					output_a_divider_o <= cfg_high[sdcp_pkg::HI_NA_LSB +: sdcp_pkg::NA_W];
					output_b_halver_o <= cfg_high[sdcp_pkg::HI_NB_BIT];
					prescale_o <= cfg_high[sdcp_pkg::HI_P_BIT];
				end
				// wraps freely, the host owns range safety
				sdcp_pkg::CMD_STEP_UP: feedback_divider_o <= feedback_divider_o + 10'h001;
				sdcp_pkg::CMD_STEP_DOWN: feedback_divider_o <= feedback_divider_o - 10'h001;
				default: feedback_divider_o <= feedback_divider_o;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	sequence s_step_cmd;
		cmd_stb && par_n_s && (wr_data == sdcp_pkg::CMD_STEP_UP);
	endsequence
	sequence s_apply_cmd;
		cmd_stb && par_n_s && (wr_data == sdcp_pkg::CMD_APPLY);
	endsequence
	a_step_up_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_step_cmd |=> feedback_divider_o == $past(feedback_divider_o) + 10'h001)
		else $error("step up did not add one");
	a_step_keeps_regs: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_step_cmd |=> $stable(cfg_low) && $stable(cfg_high))
		else $error("step command changed config registers");
	a_apply_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_apply_cmd |=> feedback_divider_o == $past({cfg_high[1:0], cfg_low}))
		else $error("apply did not load feedback latch");
	a_capture_regs: assert property (@(posedge clk_i) disable iff (!rst_n)
		cmd_stb && par_n_s && wr_data == sdcp_pkg::CMD_CAPTURE
		|=> cfg_low == $past(feedback_divider_o[7:0]))
		else $error("capture did not copy latch");
	a_write_no_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_ok && wr_addr != sdcp_pkg::REG_COMMAND && $past(par_n_s) && par_n_s
		|=> $stable(feedback_divider_o))
		else $error("register write moved latch");
	a_parallel_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
		!par_n_s |=> feedback_divider_o == $past(m_s) && prescale_o == $past(p_s))
		else $error("latch not following pins");
	a_parallel_mirror: assert property (@(posedge clk_i) disable iff (!rst_n)
		!par_n_s |=> cfg_high == $past(pins_high))
		else $error("registers not mirroring pins");
	a_write_low: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_ok && wr_addr == sdcp_pkg::REG_CFG_LOW |=> cfg_low == $past(wr_data))
		else $error("low register write lost");
	a_startup_load: assert property (@(posedge clk_i) disable iff (!rst_n)
		startup_cnt == sdcp_pkg::STARTUP_LOAD |=> feedback_divider_o == $past(m_s))
		else $error("startup capture missed");
	a_ack_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
		state == sdcp_pkg::ST_ACK && $past(state) == sdcp_pkg::ST_ACK |-> sda_oe_o)
		else $error("acknowledge not driven");
endmodule // sdcp_config_port

// file: dv/sdcp_host_model.sv
// serial host controller model that configures the divider port
module sdcp_host_model #(
	parameter int HALF = 32 // clocks per half period; keeps the bus within fast mode
) (
	input wire logic clk_i, // system clock
	input wire logic sda_i, // resolved serial data level
	output logic scl_o, // serial clock, high while idle
	output logic sda_o, // serial data drive, high releases the line
	output logic rd_valid_o, // one-clock pulse per byte read
	output logic [7:0] rd_byte_o // byte read from the device
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////
	// idle bus: both lines released to their pull-ups
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rd_valid_o = 1'b0;
		rd_byte_o = 8'h00;
	end
	task automatic half_wait();
		repeat (HALF) @(negedge clk_i);
	endtask
	// start condition: data falls while the clock is high
	task automatic start();
		sda_o = 1'b1;
		half_wait();
		sda_o = 1'b0;
		half_wait();
		scl_o = 1'b0;
	endtask
	// one bit slot; data moves two clocks after the clock fall so the
	// synchronised copies never see data and clock move together
	task automatic bit_slot(input logic b, output logic seen);
		repeat (2) @(negedge clk_i);
		sda_o = b;
		half_wait();
		scl_o = 1'b1;
		half_wait();
		seen = sda_i;
		scl_o = 1'b0;
	endtask
	// byte out, msb first, then release for the device acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], s);
		end
		bit_slot(1'b1, ack);
	endtask
	// byte in; the host acknowledges all but the last byte of a read
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, d[i]);
		end
		rd_byte_o = d;
		rd_valid_o = 1'b1;
		@(negedge clk_i);
		rd_valid_o = 1'b0;
		bit_slot(last, s);
	endtask
	// stop condition: data rises while the clock is high
	task automatic stop();
		repeat (2) @(negedge clk_i);
		sda_o = 1'b0;
		half_wait();
		scl_o = 1'b1;
		half_wait();
		sda_o = 1'b1;
		half_wait();
	endtask
endmodule // sdcp_host_model

// file: dv/sdcp_config_port_tb.sv
// self-checking bench of the divider configuration port
module sdcp_config_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SIG = 8'h3C; // arbitrary signature value
	localparam logic [14:0] DEF = {sdcp_pkg::DEF_M, sdcp_pkg::DEF_NA, sdcp_pkg::DEF_NB,
		sdcp_pkg::DEF_P};
	logic clk, rst_n, par_n, host_sda, scl, rd_valid, sda_drv, sda_oe, ack, ob, pr;
	logic [1:0] asel;
	logic [14:0] pins, keep; // {m, na, nb, p}
	logic [7:0] rd_b, lo, hi;
	logic [9:0] fb;
	logic [2:0] oa;
	logic [7:0] expq[$]; // expected read bytes, oldest first
	wire sda_w;
	wire [14:0] lat;
	int n_fail, n_compared, seed;
	////////////////////////////////////////////////////////////////////////////
	// open-drain wire with pull-up; the device only ever pulls low
	assign sda_w = host_sda & ~(sda_oe & ~sda_drv);
	assign lat = {fb, oa, ob, pr};
	sdcp_config_port #(.PART_SIGNATURE(SIG)) dut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_drv), .sda_oe_o(sda_oe), .addr_sel_i(asel),
		.parallel_mode_n_i(par_n), .m_pin_i(pins[14:5]), .na_pin_i(pins[4:2]),
		.nb_pin_i(pins[1]), .p_pin_i(pins[0]), .feedback_divider_o(fb),
		.output_a_divider_o(oa), .output_b_halver_o(ob), .prescale_o(pr));
	sdcp_host_model host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda),
		.rd_valid_o(rd_valid), .rd_byte_o(rd_b));
	////////////////////////////////////////////////////////////////////////////
	// clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// high register layout worked out independently of the design
	function automatic logic [7:0] hi_of(input logic [14:0] v);
		return {1'b0, v[4:2], v[0], v[1], v[14:13]};
	endfunction
	function automatic logic [14:0] lat_of(input logic [7:0] l, input logic [7:0] h);
		return {h[1:0], l, h[6:4], h[2], h[3]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic close_out();
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// byte effects land a few clocks after the last clock fall
	task automatic settle();
		repeat (12) @(negedge clk);
	endtask
	task automatic open_xfer(input logic rd, input logic [1:0] sel, input logic exp_ack);
		logic a;
		host.start();
		host.wr_byte({sdcp_pkg::TARGET_ADDR_HI, sel, rd}, a);
		chk({15'h0000, a}, {15'h0000, exp_ack});
	endtask
	task automatic pair(input logic [7:0] r, input logic [7:0] d);
		logic a0, a1;
		host.wr_byte(r, a0);
		host.wr_byte(d, a1);
		chk({14'h0000, a0, a1}, 16'h0000);
	endtask
	// read transfer: low, high, signature; the command register never appears
	task automatic read_all(input logic [7:0] l, input logic [7:0] h);
		logic [7:0] b;
		open_xfer(1'b1, asel, 1'b0);
		expq.push_back(l);
		expq.push_back(h);
		expq.push_back(SIG);
		host.rd_byte(1'b0, b);
		host.rd_byte(1'b0, b);
		host.rd_byte(1'b1, b);
		host.stop();
		settle();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// watcher: each byte read is matched against the oldest note
	always @(posedge clk) begin
		if (rd_valid === 1'b1) begin
			chk({8'h00, rd_b}, {8'h00, expq.pop_front()});
		end
	end
	// watchdog well beyond the expected run length
	initial begin
		#3000000;
		n_fail++;
		$display("watchdog expired");
		close_out();
	end
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'h39d2;
		rst_n = 1'b0;
		par_n = 1'b1;
		asel = 2'($random(seed));
		pins = 15'($random(seed));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		// no traffic until the latches have settled after startup
		repeat (16) @(negedge clk);
		chk({1'b0, lat}, {1'b0, pins});
		read_all(DEF[12:5], hi_of(DEF));
		done("startup");
		open_xfer(1'b0, asel, 1'b0);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_CAPTURE);
		host.stop();
		settle();
		read_all(pins[12:5], hi_of(pins));
		done("capture");
		// pairs in reverse order; top bit of the high byte reads back as zero
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		open_xfer(1'b0, asel, 1'b0);
		pair(sdcp_pkg::REG_CFG_HIGH, hi);
		pair(sdcp_pkg::REG_CFG_LOW, lo);
		host.stop();
		settle();
		chk({1'b0, lat}, {1'b0, pins});
		open_xfer(1'b0, asel, 1'b0);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_APPLY);
		pair(sdcp_pkg::REG_COMMAND, 8'h55);
		host.stop();
		settle();
		chk({1'b0, lat}, {1'b0, lat_of(lo, hi)});
		read_all(lo, hi & sdcp_pkg::HIGH_MASK);
		done("write_apply");
		// apply first, then step across the top of the feedback range
		open_xfer(1'b0, asel, 1'b0);
		pair(sdcp_pkg::REG_CFG_LOW, 8'hFF);
		pair(sdcp_pkg::REG_CFG_HIGH, 8'h23);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_APPLY);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_STEP_UP);
		host.stop();
		settle();
		chk({1'b0, lat}, {1'b0, lat_of(8'h00, 8'h20)});
		open_xfer(1'b0, asel, 1'b0);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_STEP_DOWN);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_STEP_DOWN);
		host.stop();
		settle();
		chk({1'b0, lat}, {1'b0, lat_of(8'hFE, 8'h23)});
		read_all(8'hFF, 8'h23);
		done("step");
		open_xfer(1'b0, ~asel, 1'b1);
		host.stop();
		done("other_address");
		// parallel mode: pins rule, writes ignored, reads served
		par_n = 1'b0;
		pins = 15'($random(seed));
		settle();
		chk({1'b0, lat}, {1'b0, pins});
		open_xfer(1'b0, asel, 1'b0);
		pair(sdcp_pkg::REG_CFG_LOW, ~pins[12:5]);
		pair(sdcp_pkg::REG_COMMAND, sdcp_pkg::CMD_APPLY);
		host.stop();
		settle();
		chk({1'b0, lat}, {1'b0, pins});
		read_all(pins[12:5], hi_of(pins));
		pins = 15'($random(seed));
		settle();
		chk({1'b0, lat}, {1'b0, pins});
		par_n = 1'b1;
		keep = pins;
		settle();
		pins = 15'($random(seed));
		settle();
		chk({1'b0, lat}, {1'b0, keep});
		read_all(keep[12:5], hi_of(keep));
		done("parallel");
		// reset cut into a write; no answer while it is held
		open_xfer(1'b0, asel, 1'b0);
		host.wr_byte(sdcp_pkg::REG_CFG_LOW, ack);
		rst_n = 1'b0;
		host.stop();
		open_xfer(1'b0, asel, 1'b1);
		host.stop();
		pins = DEF; // open pins: board pulls present the default setting
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (16) @(negedge clk);
		chk({1'b0, lat}, {1'b0, DEF});
		read_all(DEF[12:5], hi_of(DEF));
		done("reset");
		close_out();
	end
endmodule // sdcp_config_port_tb
